// >>> hdl/acf_sequencer.sv
// Behaviour
// - converts continuously, output register refreshed each notch period in mode 000 and once per six-phase cycle in mode 101, readable anytime
// - sample, update and calibration timing all divide down from the master clock
// - falling edge on sync input resets the filter to a known state
// - every calibration command resets the digital filter
// - results have offset subtracted, then multiplied by full-scale coefficient
// - host may write offset and full-scale coefficient registers
// - self, system and offset calibrations end with ready output going low
// - ready rises within one modulator cycle of a calibration command
// - mode 001 starts self-calibration on shorted inputs and internal reference
// - self-calibration converts shorted node first, reference second, span gives gain
// - ready falls only after coefficients update and filter resettles on input
// - self-calibration runs with the currently selected amplifier gain
// - bipolar calibration points are midscale and positive full scale
// - 33-bit internal arithmetic, 16- or 24-bit results
// - background mode absorbs gain, notch or range changes by itself
// - range selection changes coding and scale: straight binary at twice the value, or offset binary
// - mode 010 system zero step, mode 011 system full-scale step
// - mode 101 runs background calibration until the mode changes
module acf_sequencer
#(
   parameter int MOD_DIV = 256
)
(
   input logic clk,
   input logic rst_n,
   input logic [acf_pkg::ADDR_W-1:0] addr,
   input logic [acf_pkg::DATA_W-1:0] wdata,
   input logic wr,
   input logic rd,
   output logic [acf_pkg::DATA_W-1:0] rdata,
   input logic sync_n,
   input logic signed [acf_pkg::RAW_W-1:0] conv_raw,
   output logic result_ready_n,
   output logic filter_rst,
   output acf_pkg::acf_node_type node_sel,
   output logic [acf_pkg::GAIN_W-1:0] pga_gain,
   output logic cal_busy
);
   import acf_pkg::*;

   localparam int MOD_W = $clog2(MOD_DIV);

   if (MOD_DIV < 2 || MOD_DIV > 65536)
   begin : g_bad_div
      $error("MOD_DIV out of range");
   end

   logic sync_meta_r, sync_s_r, sync_d_r;
   logic [MODE_W-1:0] mode_r;
   logic bipolar_r, word24_r;
   logic [GAIN_W-1:0] gain_r;
   logic [NOTCH_W-1:0] notch_r;
   logic [MOD_W-1:0] mod_cnt_r;
   logic [NOTCH_W-1:0] out_cnt_r;
   acf_state_type state_r;
   logic [MODE_W-1:0] cmd_r;
   logic [STEP_W-1:0] step_r;
   logic [BG_W-1:0] bg_phase_r;
   logic signed [RAW_W-1:0] span_r;
   logic [RAW_W+1:0] div_rem_r;
   logic [FS_W-1:0] div_q_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic signed [RAW_W-1:0] offset_r;
   logic [FS_W-1:0] fscale_r;
   logic [RAW_W-1:0] data_r;
   logic result_ready_n_r, filter_rst_r, cal_busy_r;
   acf_node_type node_sel_r, node_nxt;
   logic [DATA_W-1:0] rdata_r;

   logic sync_fall, ctrl_wr, cal_cmd, abort_cmd, bg_cfg_chg, filt_rst;
   logic mod_tick, conv_strobe, step_last, publish, div_last;
   logic [MODE_W-1:0] new_mode;
   logic [NOTCH_W-1:0] notch_last;
   logic [STEP_W-1:0] settle_n;
   logic [RAW_W+1:0] rem_sh, rem_nxt;
   logic rem_ge;
   logic [RAW_W-1:0] math_code;
   logic [RAW_W-1:0] ofs_wdata;

   acf_cal_if cal ();
   acf_cal_math u_math (.c(cal.calc));
   assign cal.raw = conv_raw;
   assign cal.offset = offset_r;
   assign cal.fscale = fscale_r;
   assign cal.bipolar = bipolar_r;
   assign cal.word24 = word24_r;
   assign math_code = cal.code;
   assign ofs_wdata = wdata[RAW_W-1:0];

   // pin input: the second and third stages feed the edge detector, never the first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_meta_r <= 1'b1;
         sync_s_r <= 1'b1;
         sync_d_r <= 1'b1;
      end
      else
      begin
         sync_meta_r <= sync_n;
         sync_s_r <= sync_meta_r;
         sync_d_r <= sync_s_r;
      end
   end
   assign sync_fall = sync_d_r & ~sync_s_r;

   assign ctrl_wr = wr && (addr == REG_CTRL);
   assign new_mode = wdata[CTRL_MODE_LSB +: MODE_W];
   // rewriting background mode while in it is a settings change, not a new command
   assign bg_cfg_chg = ctrl_wr && (mode_r == MODE_BG) && (new_mode == MODE_BG) &&
      (wdata[CTRL_BIP_BIT] != bipolar_r || wdata[CTRL_GAIN_LSB +: GAIN_W] != gain_r ||
      wdata[CTRL_NOTCH_LSB +: NOTCH_W] != notch_r);
   assign cal_cmd = ctrl_wr && (new_mode >= MODE_SELF) && (new_mode <= MODE_BG) &&
      !((mode_r == MODE_BG) && (new_mode == MODE_BG));
   assign abort_cmd = ctrl_wr && !((new_mode >= MODE_SELF) && (new_mode <= MODE_BG));
   assign filt_rst = sync_fall || cal_cmd || bg_cfg_chg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r <= MODE_NORMAL;
         bipolar_r <= 1'b0;
         word24_r <= 1'b1;
         gain_r <= GAIN_RST;
         notch_r <= NOTCH_RST;
      end
      else if (ctrl_wr)
      begin
         mode_r <= new_mode;
         bipolar_r <= wdata[CTRL_BIP_BIT];
         word24_r <= wdata[CTRL_W24_BIT];
         gain_r <= wdata[CTRL_GAIN_LSB +: GAIN_W];
         notch_r <= wdata[CTRL_NOTCH_LSB +: NOTCH_W];
      end
   end

   // a notch of zero behaves as one modulator cycle per result
   assign notch_last = (notch_r == '0) ? '0 : notch_r - 1'b1;
   assign mod_tick = (mod_cnt_r == MOD_W'(MOD_DIV - 1));
   // a notch lowered mid-count ends the period at the next modulator tick instead of wrapping the counter
   assign conv_strobe = mod_tick && (out_cnt_r >= notch_last);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mod_cnt_r <= '0;
         out_cnt_r <= '0;
      end
      else if (filt_rst)
      begin
         mod_cnt_r <= '0;
         out_cnt_r <= '0;
      end
      else
      begin
         mod_cnt_r <= mod_tick ? '0 : mod_cnt_r + 1'b1;
         if (conv_strobe)
         begin
            out_cnt_r <= '0;
         end
         else if (mod_tick)
         begin
            out_cnt_r <= out_cnt_r + 1'b1;
         end
      end
   end

   assign settle_n = (cmd_r == MODE_SYS_ZERO || cmd_r == MODE_SYS_FULL) ? SETTLE_SYS
      : SETTLE_SELF;
   assign step_last = (state_r == ST_SETTLE) ? (step_r == settle_n - 1'b1)
      : (step_r == CAL_MEAS_CONV - 1'b1);
   assign div_last = (div_cnt_r == DIV_STEPS - 1'b1);
   assign rem_sh = {div_rem_r[RAW_W:0], 1'b0};
   assign rem_ge = rem_sh >= {2'b00, span_r};
   assign rem_nxt = rem_ge ? rem_sh - {2'b00, span_r} : rem_sh;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_RUN;
         cmd_r <= MODE_NORMAL;
         step_r <= '0;
         bg_phase_r <= '0;
         span_r <= '0;
         div_rem_r <= '0;
         div_q_r <= '0;
         div_cnt_r <= '0;
      end
      else if (cal_cmd)
      begin
         cmd_r <= new_mode;
         step_r <= '0;
         bg_phase_r <= '0;
         if (new_mode == MODE_BG)
         begin
            state_r <= ST_BG;
         end
         else if (new_mode == MODE_SYS_FULL)
         begin
            state_r <= ST_FULL;
         end
         else
         begin
            state_r <= ST_ZERO;
         end
      end
      else if (abort_cmd)
      begin
         state_r <= ST_RUN;
      end
      else if (bg_cfg_chg)
      begin
         bg_phase_r <= '0;
      end
      else
      begin
         case (state_r)
            ST_ZERO:
            begin
               if (conv_strobe)
               begin
                  step_r <= step_last ? '0 : step_r + 1'b1;
                  if (step_last)
                  begin
                     // a lone zero step keeps the slope from the last full calibration
                     state_r <= (cmd_r == MODE_SYS_ZERO) ? ST_SETTLE : ST_FULL;
                  end
               end
            end
            ST_FULL:
            begin
               if (conv_strobe)
               begin
                  step_r <= step_last ? '0 : step_r + 1'b1;
                  if (step_last)
                  begin
                     span_r <= conv_raw - offset_r;
                     div_rem_r <= DIV_REM_INIT;
                     div_cnt_r <= '0;
                     state_r <= ST_DIV;
                  end
               end
            end
            ST_DIV:
            begin
               div_rem_r <= rem_nxt;
               div_q_r <= {div_q_r[FS_W-2:0], rem_ge};
               div_cnt_r <= div_cnt_r + 1'b1;
               if (div_last)
               begin
                  state_r <= (cmd_r == MODE_BG) ? ST_BG : ST_SETTLE;
               end
            end
            ST_SETTLE:
            begin
               if (conv_strobe)
               begin
                  step_r <= step_last ? '0 : step_r + 1'b1;
                  if (step_last)
                  begin
                     state_r <= ST_RUN;
                  end
               end
            end
            ST_BG:
            begin
               if (conv_strobe)
               begin
                  bg_phase_r <= (bg_phase_r == BG_FULL_PH) ? '0 : bg_phase_r + 1'b1;
                  if (bg_phase_r == BG_FULL_PH)
                  begin
                     span_r <= conv_raw - offset_r;
                     div_rem_r <= DIV_REM_INIT;
                     div_cnt_r <= '0;
                     state_r <= ST_DIV;
                  end
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // coefficient updates from calibration take priority over host writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         offset_r <= OFFSET_RST;
         fscale_r <= FS_UNITY;
      end
      else
      begin
         if (!cal_cmd && conv_strobe && ((state_r == ST_ZERO && step_last) ||
            (state_r == ST_BG && bg_phase_r == BG_ZERO_PH)))
         begin
            offset_r <= conv_raw;
         end
         else if (wr && addr == REG_OFFSET)
         begin
            offset_r <= ofs_wdata;
         end
         if (!cal_cmd && !abort_cmd && state_r == ST_DIV && div_last)
         begin
            // a collapsed span would overflow the quotient: pin to maximum gain
            fscale_r <= (span_r <= DIV_SPAN_MIN) ? FS_MAX
               : {div_q_r[FS_W-2:0], rem_ge};
         end
         else if (wr && addr == REG_FSCALE)
         begin
            fscale_r <= wdata[FS_W-1:0];
         end
      end
   end

   assign publish = conv_strobe && !bg_cfg_chg && ((state_r == ST_RUN) ||
      (state_r == ST_BG && bg_phase_r == BG_PUB_PH) ||
      (state_r == ST_SETTLE && step_last));

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_r <= '0;
         result_ready_n_r <= 1'b1;
      end
      else if (cal_cmd)
      begin
         result_ready_n_r <= 1'b1;
      end
      else if (publish && !abort_cmd)
      begin
         data_r <= math_code;
         result_ready_n_r <= 1'b0;
      end
      else if (rd && addr == REG_DATA)
      begin
         result_ready_n_r <= 1'b1;
      end
   end

   always_comb
   begin
      case (state_r)
         ST_ZERO: node_nxt = (cmd_r == MODE_SELF) ? NODE_SHORT : NODE_AIN;
         ST_FULL: node_nxt = (cmd_r == MODE_SYS_FULL) ? NODE_AIN : NODE_VREF;
         ST_BG: node_nxt = (bg_phase_r == BG_ZERO_PH) ? NODE_SHORT
            : (bg_phase_r == BG_FULL_PH) ? NODE_VREF : NODE_AIN;
         default: node_nxt = NODE_AIN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         node_sel_r <= NODE_AIN;
         filter_rst_r <= 1'b0;
         cal_busy_r <= 1'b0;
      end
      else
      begin
         node_sel_r <= node_nxt;
         filter_rst_r <= filt_rst;
         cal_busy_r <= (state_r != ST_RUN) && (state_r != ST_BG);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= '0;
      end
      else if (rd)
      begin
         case (addr)
            REG_CTRL: rdata_r <= {12'h000, notch_r, gain_r, word24_r, bipolar_r, mode_r};
            REG_DATA: rdata_r <= {8'h00, data_r};
            REG_OFFSET: rdata_r <= {8'h00, offset_r};
            REG_FSCALE: rdata_r <= {7'h00, fscale_r};
            REG_STATUS: rdata_r <= {29'h0, mode_r == MODE_BG, cal_busy_r, result_ready_n_r};
            default: rdata_r <= '0;
         endcase
      end
      else
      begin
         rdata_r <= '0;
      end
   end

   assign rdata = rdata_r;
   assign result_ready_n = result_ready_n_r;
   assign filter_rst = filter_rst_r;
   assign node_sel = node_sel_r;
   // amplifier gain stays applied through calibration, so coefficients include it
   assign pga_gain = gain_r;
   assign cal_busy = cal_busy_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sync_filter_rst_a: assert property (sync_fall |=> filter_rst_r && mod_cnt_r == '0)
      else $error("sync edge did not reset filter");
   cal_filter_rst_a: assert property (cal_cmd |=> filter_rst_r && out_cnt_r == '0)
      else $error("calibration command did not reset filter");
   cal_ready_up_a: assert property (cal_cmd |=> result_ready_n_r [*2])
      else $error("ready not raised after calibration command");
   cal_hold_a: assert property ((state_r == ST_ZERO || state_r == ST_FULL ||
      (state_r == ST_DIV && cmd_r != MODE_BG)) |-> result_ready_n_r)
      else $error("ready low during calibration");
   publish_data_a: assert property (publish && !cal_cmd && !abort_cmd |=>
      !result_ready_n_r && data_r == $past(math_code))
      else $error("result not published");
   cal_done_a: assert property (state_r == ST_SETTLE && step_last && conv_strobe && !wr |=>
      state_r == ST_RUN && !result_ready_n_r)
      else $error("calibration end not signalled");
   self_start_a: assert property (cal_cmd && new_mode == MODE_SELF |=>
      state_r == ST_ZERO ##1 node_sel_r == NODE_SHORT)
      else $error("self calibration did not start on shorted node");
   self_full_a: assert property (state_r == ST_FULL && cmd_r == MODE_SELF &&
      $past(state_r) == ST_FULL |-> node_sel_r == NODE_VREF)
      else $error("reference node not selected");
   offset_wr_a: assert property (wr && addr == REG_OFFSET && state_r == ST_RUN |=>
      offset_r == $past(ofs_wdata))
      else $error("offset write lost");
   bg_change_a: assert property (bg_cfg_chg |=> filter_rst_r && bg_phase_r == '0)
      else $error("background mode ignored settings change");

   self_done_c: cover property (state_r == ST_SETTLE && cmd_r == MODE_SELF ##1
      state_r == ST_RUN);
   bg_publish_c: cover property (state_r == ST_BG && publish);
   sync_c: cover property (sync_fall);
endmodule

// >>> hdl/acf_pkg.sv
package acf_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] REG_DATA = 3'h1;
   localparam logic [ADDR_W-1:0] REG_OFFSET = 3'h2;
   localparam logic [ADDR_W-1:0] REG_FSCALE = 3'h3;
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;

   localparam int MODE_W = 3;
   localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
   localparam logic [MODE_W-1:0] MODE_SELF = 3'h1;
   localparam logic [MODE_W-1:0] MODE_SYS_ZERO = 3'h2;
   localparam logic [MODE_W-1:0] MODE_SYS_FULL = 3'h3;
   localparam logic [MODE_W-1:0] MODE_SYS_OFS = 3'h4;
   localparam logic [MODE_W-1:0] MODE_BG = 3'h5;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_BIP_BIT = 3;
   localparam int CTRL_W24_BIT = 4;
   localparam int CTRL_GAIN_LSB = 5;
   localparam int GAIN_W = 3;
   localparam int CTRL_NOTCH_LSB = 8;
   localparam int NOTCH_W = 12;
   localparam logic [NOTCH_W-1:0] NOTCH_RST = 12'h100;
   localparam logic [GAIN_W-1:0] GAIN_RST = 3'h0;

   localparam int RAW_W = 24;
   localparam int FS_W = 25;
   localparam int FS_FRAC = 23;
   localparam int INT_W = 33;
   localparam logic [RAW_W-1:0] OFFSET_RST = 24'h00_0000;
   localparam logic [FS_W-1:0] FS_UNITY = 25'h080_0000;
   localparam logic [FS_W-1:0] FS_MAX = 25'h1ff_ffff;
   localparam logic signed [INT_W:0] CODE_MAX = 34'sh0_00ff_ffff;
   localparam logic signed [INT_W:0] CODE_MID = 34'sh0_0080_0000;

   localparam int STEP_W = 4;
   localparam logic [STEP_W-1:0] CAL_MEAS_CONV = 4'h3;
   localparam logic [STEP_W-1:0] SETTLE_SELF = 4'h3;
   localparam logic [STEP_W-1:0] SETTLE_SYS = 4'h1;
   localparam int BG_W = 3;
   localparam logic [BG_W-1:0] BG_PUB_PH = 3'h3;
   localparam logic [BG_W-1:0] BG_ZERO_PH = 3'h4;
   localparam logic [BG_W-1:0] BG_FULL_PH = 3'h5;

   localparam int DIV_W = 5;
   localparam logic [DIV_W-1:0] DIV_STEPS = 5'h19;
   localparam logic [RAW_W+1:0] DIV_REM_INIT = 26'h020_0000;
   localparam logic signed [RAW_W-1:0] DIV_SPAN_MIN = 24'sh20_0000;

   typedef enum logic [1:0] {NODE_AIN, NODE_SHORT, NODE_VREF} acf_node_type;
   typedef enum logic [2:0] {ST_RUN, ST_ZERO, ST_FULL, ST_DIV, ST_SETTLE, ST_BG} acf_state_type;
endpackage

// >>> hdl/acf_cal_if.sv
interface acf_cal_if;
   import acf_pkg::*;
   logic signed [RAW_W-1:0] raw;
   logic signed [RAW_W-1:0] offset;
   logic [FS_W-1:0] fscale;
   logic bipolar;
   logic word24;
   logic [RAW_W-1:0] code;
   modport calc(input raw, input offset, input fscale, input bipolar, input word24, output code);
   modport user(output raw, output offset, output fscale, output bipolar, output word24,
      input code);
endinterface

// >>> hdl/acf_cal_math.sv
module acf_cal_math
(
   acf_cal_if.calc c
);
   import acf_pkg::*;

   logic signed [RAW_W:0] diff;
   logic signed [RAW_W+FS_W+1:0] prod;
   logic signed [INT_W-1:0] internal;
   logic signed [INT_W:0] val;
   logic [RAW_W-1:0] clamped;

   // offset removed before the gain multiply
   assign diff = {c.raw[RAW_W-1], c.raw} - {c.offset[RAW_W-1], c.offset};
   assign prod = diff * $signed({1'b0, c.fscale});
   // 33-bit internal result, trimmed to the published width below
   assign internal = INT_W'(prod >>> FS_FRAC);

   // zero input sits at code 0 unipolar, at midscale bipolar; unipolar also doubles the value
   always_comb
   begin
      if (c.bipolar)
      begin
         val = {internal[INT_W-1], internal} + CODE_MID;
      end
      else
      begin
         val = {internal, 1'b0};
      end
      if (val < 0)
      begin
         clamped = '0;
      end
      else if (val > CODE_MAX)
      begin
         clamped = CODE_MAX[RAW_W-1:0];
      end
      else
      begin
         clamped = val[RAW_W-1:0];
      end
   end

   // short words keep the top sixteen bits, right aligned
   assign c.code = c.word24 ? clamped : {8'h00, clamped[RAW_W-1:8]};
endmodule

// >>> tb/acf_front_model.sv
module acf_front_model
#(
   parameter logic signed [23:0] SHORT_LVL = 24'sh00_0100,
   parameter logic signed [23:0] VREF_LVL = 24'sh40_0100
)
(
   input acf_pkg::acf_node_type node_sel,
   input logic [acf_pkg::GAIN_W-1:0] pga_gain,
   input logic signed [acf_pkg::RAW_W-1:0] ain,
   output logic signed [acf_pkg::RAW_W-1:0] conv_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   import acf_pkg::*;
   // gain is taken as unity here; the node alone picks the level
   always_comb
   begin
      case (node_sel)
         NODE_SHORT: conv_raw = SHORT_LVL;
         NODE_VREF: conv_raw = VREF_LVL;
         default: conv_raw = ain;
      endcase
   end
endmodule

// >>> tb/adc_calibration_filter_sequencer_tb_top.sv
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module adc_calibration_filter_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import acf_pkg::*;
   localparam int MOD_DIV = 4;
   localparam logic signed [RAW_W-1:0] AIN = 24'sh10_0000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = 3'h0;
   logic [DATA_W-1:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sync_n = 1'b1;
   logic [DATA_W-1:0] rdata;
   logic signed [RAW_W-1:0] conv_raw;
   logic result_ready_n, filter_rst, cal_busy;
   acf_node_type node_sel;
   logic [GAIN_W-1:0] pga_gain;
   int n_errors = 0;
   int n_compared = 0;
   int n_frst = 0;
   logic [DATA_W-1:0] d;

   acf_sequencer #(.MOD_DIV(MOD_DIV)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sync_n(sync_n), .conv_raw(conv_raw),
      .result_ready_n(result_ready_n), .filter_rst(filter_rst), .node_sel(node_sel),
      .pga_gain(pga_gain), .cal_busy(cal_busy));
   acf_front_model u_front (.node_sel(node_sel), .pga_gain(pga_gain), .ain(AIN),
      .conv_raw(conv_raw));

   always #20 clk = ~clk;
   always @(posedge clk) if (filter_rst === 1'b1) n_frst <= n_frst + 1;

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_ready(input int lim);
      int i;
      i = 0;
      while (result_ready_n !== 1'b0 && i < lim)
      begin
         @(posedge clk);
         #1 i++;
      end
   endtask
   task automatic start_cal(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] base);
      int f0;
      f0 = n_frst;
      wr_reg(REG_CTRL, base | 32'(m));
      // ready is not trusted for one modulator cycle after the command
      repeat (MOD_DIV) @(posedge clk);
      #1;
      `CHK(n_frst > f0, 1'b1)
      `CHK(result_ready_n, 1'b1)
      if (m != MODE_BG) `CHK(cal_busy, 1'b1)
   endtask

   task automatic t_reset;
      rd_reg(REG_CTRL, d);
      `CHK(d, 32'h0001_0010)
      @(posedge clk);
      #1 `CHK(rdata, 32'h0)
      rd_reg(REG_OFFSET, d);
      `CHK(d, 32'h0)
      rd_reg(REG_FSCALE, d);
      `CHK(d, 32'h0080_0000)
      rd_reg(3'h5, d);
      `CHK(d, 32'h0)
      $display("test reset done");
   endtask
   task automatic t_convert;
      wr_reg(REG_CTRL, 32'h0000_0100);
      rd_reg(REG_DATA, d);
      wait_ready(100);
      `CHK(result_ready_n, 1'b0)
      rd_reg(REG_DATA, d);
      `CHK(d, 32'h0000_2000)
      $display("test convert done");
   endtask
   task automatic t_coeffs;
      wr_reg(REG_CTRL, 32'h0000_0110);
      wr_reg(REG_OFFSET, 32'h0001_0000);
      wr_reg(REG_FSCALE, 32'h0100_0000);
      rd_reg(REG_OFFSET, d);
      `CHK(d, 32'h0001_0000)
      rd_reg(REG_FSCALE, d);
      `CHK(d, 32'h0100_0000)
      rd_reg(REG_DATA, d);
      wait_ready(100);
      rd_reg(REG_DATA, d);
      `CHK(d, 32'h003c_0000)
      $display("test coeffs done");
   endtask
   task automatic t_selfcal;
      start_cal(MODE_SELF, 32'h0000_0110);
      `CHK(node_sel, NODE_SHORT)
      wait_ready(400);
      `CHK(result_ready_n, 1'b0)
      // busy flag trails the state by one cycle
      @(posedge clk);
      #1 `CHK(cal_busy, 1'b0)
      rd_reg(REG_OFFSET, d);
      `CHK(d, 32'h0000_0100)
      rd_reg(REG_FSCALE, d);
      `CHK(d, 32'h0100_0000)
      rd_reg(REG_DATA, d);
      `CHK(d, 32'h003f_fc00)
      $display("test selfcal done");
   endtask
   task automatic t_bipolar;
      wr_reg(REG_CTRL, 32'h0000_0178);
      rd_reg(REG_DATA, d);
      `CHK(pga_gain, 3'h3)
      wait_ready(100);
      rd_reg(REG_DATA, d);
      `CHK(d, 32'h009f_fe00)
      $display("test bipolar done");
   endtask
   task automatic t_sync;
      int f0;
      f0 = n_frst;
      @(posedge clk);
      sync_n <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK(n_frst > f0, 1'b1)
      sync_n <= 1'b1;
      wait_ready(100);
      `CHK(result_ready_n, 1'b0)
      $display("test sync done");
   endtask
   task automatic t_modes;
      logic [MODE_W-1:0] m;
      int f0;
      // range changed above, so the host calibrates again
      for (int k = 2; k <= 5; k++)
      begin
         m = MODE_W'(k);
         start_cal(m, 32'h0000_0110);
         wait_ready(400);
         `CHK(result_ready_n, 1'b0)
         if (m == MODE_SYS_ZERO)
         begin
            rd_reg(REG_OFFSET, d);
            `CHK(d, 32'(AIN))
         end
      end
      rd_reg(REG_DATA, d);
      wait_ready(400);
      `CHK(result_ready_n, 1'b0)
      rd_reg(REG_STATUS, d);
      `CHK(d, 32'h0000_0004)
      // new gain while in background mode: filter restarts, no command needed
      f0 = n_frst;
      wr_reg(REG_CTRL, 32'h0000_0135);
      repeat (2) @(posedge clk);
      #1 `CHK(n_frst > f0, 1'b1)
      `CHK(pga_gain, 3'h1)
      wr_reg(REG_CTRL, 32'h0000_0110);
      $display("test modes done");
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_convert();
      t_coeffs();
      t_selfcal();
      t_bipolar();
      t_sync();
      t_modes();
      print_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
endmodule
